// ---- verilog/pmtr_defines.vh ----
`ifndef PMTR_DEFINES_VH
`define PMTR_DEFINES_VH
// ----------------------------------------------------------------
// Program store geometry
// ----------------------------------------------------------------
`define PMTR_ADDR_W      12
`define PMTR_WORD_W      15
`define PMTR_DEPTH       4096
`define PMTR_RESET_PC    12'h000
// ----------------------------------------------------------------
// Table read layout and timing
// ----------------------------------------------------------------
`define PMTR_LOW_MSB     7
`define PMTR_HIGH_LSB    8
`define PMTR_HIGH_MSB    14
`define PMTR_LATCH_RST   8'h00
`define PMTR_TBL_CYCLES  2
`define PMTR_PAGE_LAST   4'hF
`endif

// ---- verilog/pmtr_sync.v ----
`timescale 1ns/1ps
`default_nettype none
module pmtr_sync
(
  // Clock and reset
  input  wire       clk,
  input  wire       rst_b,
  // Level in and out
  input  wire       d,
  output wire       q
);
  reg meta_r;
  reg q_r;
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      meta_r <= 1'b0;
      q_r    <= 1'b0;
    end
    else
    begin
      meta_r <= d;
      q_r    <= meta_r;
    end
  end
  assign q = q_r;
endmodule // pmtr_sync
`default_nettype wire

// ---- verilog/pmtr_top.v ----
// Operation
// - 4K by 15-bit program store, PC addressed.
// - Reset loads PC with 000H.
// - Table address is high pointer then low.
// - Table pointer independent of program counter.
// - Low byte goes to operand register.
// - Upper bits go to table high latch.
// - Latch bits without word bits read zero.
// - Table instructions take two instruction cycles.
// - Latch read-only; only table reads update it.
// - Serial data line shared, clocked by programmer.
// - Debug pins still serve as programming pins.
// - Debug data bidirectional, debug clock input only.
// - Shared pin functions disabled while debugging.
// - PC twelve bits: four hidden, eight visible.
`timescale 1ns/1ps
`default_nettype none
`include "pmtr_defines.vh"
module pmtr_top
#(
  parameter ADDR_W = `PMTR_ADDR_W,
  parameter WORD_W = `PMTR_WORD_W,
  parameter DEPTH  = `PMTR_DEPTH
)
(
  // Clock and reset
  input  wire              ref_clk,
  input  wire              rst_b,
  // Core fetch control, one pulse per instruction cycle
  input  wire              instr_cycle,
  input  wire              pc_load,
  input  wire [ADDR_W-1:0] pc_load_val,
  input  wire              pc_low_wr,
  input  wire [7:0]        pc_low_wdata,
  output wire [ADDR_W-1:0] pc,
  output wire [7:0]        pc_low_byte,
  output wire [WORD_W-1:0] fetch_word,
  output wire              fetch_valid,
  output wire              fetch_stall,
  // Table read request from the core
  input  wire              tbl_rd,
  input  wire              tbl_last_page,
  input  wire [7:0]        tbl_ptr_low,
  input  wire [3:0]        tbl_ptr_high,
  input  wire [7:0]        tbl_dest_sel,
  input  wire              tbl_high_wr,
  output wire              tbl_busy,
  output wire              dst_wr,
  output wire [7:0]        dst_sel,
  output wire [7:0]        dst_data,
  output wire [7:0]        table_high_latch,
  // Serial programming and debug pins
  input  wire              dbg_mode,
  input  wire              prog_serial_io_i,
  output wire              prog_serial_io_o,
  output wire              prog_serial_io_oe,
  input  wire              prog_serial_clk,
  output wire              prog_sample,
  output wire              prog_clk_rise,
  output wire              pin_func_en,
  // Program store write port and serial output drive for the programming engine
  input  wire              st_wr,
  input  wire [ADDR_W-1:0] st_waddr,
  input  wire [WORD_W-1:0] st_wdata,
  input  wire              prog_out_en,
  input  wire              prog_out_bit
);
  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  reg rst_s1_r;
  reg rst_s2_r;
  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end
    else
    begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end
  wire rst_n = rst_s2_r;

  // ----------------------------------------------------------------
  // Program store
  // ----------------------------------------------------------------
  reg [WORD_W-1:0] mem_r [0:DEPTH-1];
  always @(posedge ref_clk)
  begin
    if (st_wr)
      mem_r[st_waddr] <= st_wdata;
  end

  // ----------------------------------------------------------------
  // Fetch and table read sequencer
  // ----------------------------------------------------------------
  localparam ST_RUN  = 1'b0;
  localparam ST_TBL2 = 1'b1;
  reg              state_r;
  reg [ADDR_W-1:0] pc_r;
  reg [WORD_W-1:0] fword_r;
  reg              fvalid_r;
  reg [ADDR_W-1:0] taddr_r;
  reg [7:0]        tdst_r;
  reg              dwr_r;
  reg [7:0]        dsel_r;
  reg [7:0]        ddata_r;
  reg [7:0]        latch_r;
  wire [WORD_W-1:0] tword = mem_r[taddr_r];
  // Last-page variant forces the page bits, leaving the pointer itself alone.
  wire [3:0] tpage = tbl_last_page ? `PMTR_PAGE_LAST : tbl_ptr_high;
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r  <= ST_RUN;
      pc_r     <= `PMTR_RESET_PC;
      fword_r  <= {WORD_W{1'b0}};
      fvalid_r <= 1'b0;
      taddr_r  <= {ADDR_W{1'b0}};
      tdst_r   <= 8'h00;
      dwr_r    <= 1'b0;
      dsel_r   <= 8'h00;
      ddata_r  <= 8'h00;
      latch_r  <= `PMTR_LATCH_RST;
    end
    else
    begin
      dwr_r    <= 1'b0;
      fvalid_r <= 1'b0;
      // Software writes to the latch are dropped; a table read below still lands.
      if (tbl_high_wr)
        latch_r <= latch_r;
      if (instr_cycle)
      begin
        case (state_r)
          ST_RUN:
          begin
            if (tbl_rd)
            begin
              taddr_r <= {tpage, tbl_ptr_low};
              tdst_r  <= tbl_dest_sel;
              state_r <= ST_TBL2;
            end
            else
            begin
              fword_r  <= mem_r[pc_r];
              fvalid_r <= 1'b1;
              if (pc_load)
                pc_r <= pc_load_val;
              else if (pc_low_wr)
                pc_r <= {pc_r[ADDR_W-1:8], pc_low_wdata};
              else
                pc_r <= pc_r + {{(ADDR_W-1){1'b0}}, 1'b1};
            end
          end
          ST_TBL2:
          begin
            dwr_r   <= 1'b1;
            dsel_r  <= tdst_r;
            ddata_r <= tword[`PMTR_LOW_MSB:0];
            latch_r <= {1'b0, tword[`PMTR_HIGH_MSB:`PMTR_HIGH_LSB]};
            state_r <= ST_RUN;
          end
          default:
            state_r <= ST_RUN;
        endcase
      end
    end
  end
  assign pc               = pc_r;
  assign pc_low_byte      = pc_r[7:0];
  assign fetch_word       = fword_r;
  assign fetch_valid      = fvalid_r;
  assign fetch_stall      = (state_r == ST_TBL2);
  assign tbl_busy         = (state_r == ST_TBL2);
  assign dst_wr           = dwr_r;
  assign dst_sel          = dsel_r;
  assign dst_data         = ddata_r;
  assign table_high_latch = latch_r;

  // ----------------------------------------------------------------
  // Serial programming and debug pins
  // ----------------------------------------------------------------
  // All three pins cross from the tool's clock, so each passes two flops.
  wire sclk_s;
  wire sdat_s;
  wire dbg_s;
  pmtr_sync u_sync_clk
  (
    .clk   (ref_clk),
    .rst_b (rst_n),
    .d     (prog_serial_clk),
    .q     (sclk_s)
  );
  pmtr_sync u_sync_dat
  (
    .clk   (ref_clk),
    .rst_b (rst_n),
    .d     (prog_serial_io_i),
    .q     (sdat_s)
  );
  pmtr_sync u_sync_dbg
  (
    .clk   (ref_clk),
    .rst_b (rst_n),
    .d     (dbg_mode),
    .q     (dbg_s)
  );
  reg sclk_d_r;
  reg samp_r;
  reg rise_r;
  reg oe_r;
  reg out_r;
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sclk_d_r <= 1'b0;
      samp_r   <= 1'b0;
      rise_r   <= 1'b0;
      oe_r     <= 1'b0;
      out_r    <= 1'b0;
    end
    else
    begin
      sclk_d_r <= sclk_s;
      rise_r   <= sclk_s & ~sclk_d_r;
      if (sclk_s & ~sclk_d_r)
        samp_r <= sdat_s;
      // Drive changes only on the falling edge so the tool samples on the rise.
      if (~sclk_s & sclk_d_r)
      begin
        oe_r  <= prog_out_en;
        out_r <= prog_out_bit;
      end
    end
  end
  assign prog_serial_io_o  = out_r;
  assign prog_serial_io_oe = oe_r;
  assign prog_sample       = samp_r;
  assign prog_clk_rise     = rise_r;
  assign pin_func_en       = ~dbg_s;
endmodule // pmtr_top
`default_nettype wire

// ---- tb/pmtr_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
// --------
// Checker
// --------
module pmtr_properties
(
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        rst_b,
  // Watched ports
  input wire logic        instr_cycle,
  input wire logic        tbl_rd,
  input wire logic        tbl_busy,
  input wire logic        fetch_stall,
  input wire logic        fetch_valid,
  input wire logic        dst_wr,
  input wire logic [11:0] pc,
  input wire logic [7:0]  pc_low_byte,
  input wire logic [7:0]  table_high_latch,
  input wire logic        dbg_mode,
  input wire logic        pin_func_en
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  pc_reset_a: assert property ($rose(rst_b) |-> pc == 12'h000)
    else $error("pc start");
  pc_low_a: assert property (pc_low_byte == pc[7:0])
    else $error("pc low");
  latch_top_a: assert property (!table_high_latch[7])
    else $error("latch bit 7");
  tbl_stall_a: assert property (instr_cycle && tbl_rd && !tbl_busy |=> tbl_busy)
    else $error("no stall");
  stall_same_a: assert property (fetch_stall == tbl_busy)
    else $error("stall");
  stall_hold_a: assert property (fetch_stall |=> $stable(pc) && !fetch_valid)
    else $error("fetch during stall");
  dst_end_a: assert property (dst_wr |-> $past(tbl_busy) && !tbl_busy)
    else $error("dst timing");
  latch_ro_a: assert property ($changed(table_high_latch) |-> dst_wr)
    else $error("latch write");
  dbg_off_a: assert property ($rose(dbg_mode) |-> ##[1:4] !pin_func_en)
    else $error("pins on");
endmodule // pmtr_properties
bind pmtr_top pmtr_properties pmtr_properties_i (.ref_clk, .rst_b, .instr_cycle,
  .tbl_rd, .tbl_busy, .fetch_stall, .fetch_valid, .dst_wr, .pc, .pc_low_byte, .table_high_latch,
  .dbg_mode, .pin_func_en);
`default_nettype wire

// ---- tb/pmtr_prog_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module pmtr_prog_model
(
  // Device side
  input  wire logic dev_oe,
  input  wire logic dev_o,
  // Programmer side
  output var  logic sclk,
  output var  logic line
);
  logic drv = 1'b0;
  logic b_r = 1'b0;
  initial
    sclk = 1'b0;
  // No pull on the line, so a released line shows the inverse of its last bit.
  always @*
    line = dev_oe ? dev_o : (drv ? b_r : ~b_r);
  task send(input logic [7:0] b);
    drv = 1'b1;
    for (int k = 7; k >= 0; k--)
    begin
      b_r = b[k];
      #80 sclk = 1'b1;
      #80 sclk = 1'b0;
    end
    drv = 1'b0;
  endtask
  // Clock pulses with the line released, so the device may answer on it.
  task pulse(input int n);
    for (int k = 0; k < n; k++)
    begin
      #80 sclk = 1'b1;
      #80 sclk = 1'b0;
    end
  endtask
endmodule // pmtr_prog_model
`default_nettype wire

// ---- tb/program_memory_table_read_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module program_memory_table_read_bench;
  logic        ref_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        instr_cycle = 1'b0;
  logic        tbl_rd = 1'b0;
  logic        tbl_last_page = 1'b0;
  logic        tbl_high_wr = 1'b0;
  logic        dbg_mode = 1'b0;
  logic        st_wr = 1'b0;
  logic        pc_load = 1'b0;
  logic        pc_low_wr = 1'b0;
  logic        prog_out_en = 1'b0;
  logic        prog_out_bit = 1'b0;
  logic [7:0]  tbl_ptr_low = 8'h00;
  logic [3:0]  tbl_ptr_high = 4'h0;
  logic [7:0]  tbl_dest_sel = 8'h00;
  logic [11:0] st_waddr = 12'h000;
  logic [14:0] st_wdata = 15'h0000;
  logic [11:0] a;
  logic [11:0] e;
  logic [11:0] pcx;
  logic [7:0]  sb;
  wire         sclk, sline, oe, so, fetch_valid, dst_wr, pin_func_en;
  wire         prog_sample, prog_clk_rise;
  wire  [14:0] fetch_word;
  wire  [7:0]  dst_sel, dst_data, table_high_latch;
  logic [14:0] m [0:4095];
  logic [23:0] q [$];
  integer      n_errors = 0;
  integer      tests_run = 0;
  integer      seed = 32'hC9C86948;
  always #2 ref_clk = ~ref_clk;
  pmtr_top pmtr_top_i (.ref_clk, .rst_b, .instr_cycle, .pc_load,
    .pc_load_val({tbl_ptr_high, tbl_ptr_low}), .pc_low_wr, .pc_low_wdata(tbl_dest_sel),
    .pc(), .pc_low_byte(), .fetch_word, .fetch_valid, .fetch_stall(), .tbl_rd, .tbl_last_page,
    .tbl_ptr_low, .tbl_ptr_high, .tbl_dest_sel, .tbl_high_wr, .tbl_busy(), .dst_wr, .dst_sel,
    .dst_data, .table_high_latch, .dbg_mode, .prog_serial_io_i(sline), .prog_serial_io_o(so),
    .prog_serial_io_oe(oe), .prog_serial_clk(sclk), .prog_sample, .prog_clk_rise,
    .pin_func_en, .st_wr, .st_waddr, .st_wdata, .prog_out_en, .prog_out_bit);
  pmtr_prog_model pmtr_prog_model_i (.dev_oe(oe), .dev_o(so), .sclk, .line(sline));
  task chk(input logic [23:0] got, input logic [23:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task stop_test;
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  function automatic logic [23:0] nx;
    nx = q.size() ? q.pop_front() : 'x;
  endfunction
  task cyc(input logic t);
    instr_cycle <= 1'b1;
    tbl_rd <= t;
    @(posedge ref_clk);
    instr_cycle <= 1'b0;
    tbl_rd <= 1'b0;
    repeat (3) @(posedge ref_clk);
  endtask
  task wr(input logic [11:0] ad);
    m[ad] = 15'($random(seed));
    st_wr <= 1'b1;
    st_waddr <= ad;
    st_wdata <= m[ad];
    @(posedge ref_clk);
    st_wr <= 1'b0;
    @(posedge ref_clk);
  endtask
  task drain;
    for (int i = 0; i < 100 && q.size() > 0; i++)
      @(posedge ref_clk);
    if (q.size() > 0)
      chk(24'h1, 24'h0);
  endtask
  // Results are compared in the order the requests were made.
  always @(posedge ref_clk)
  begin
    if (dst_wr === 1'b1)
      chk({dst_sel, dst_data, table_high_latch}, nx());
    if (fetch_valid === 1'b1)
      chk({9'h000, fetch_word}, nx());
    if (prog_clk_rise === 1'b1)
      chk({23'h0, prog_sample}, nx());
  end
  initial
  begin
    repeat (20) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (5) @(posedge ref_clk);
    a = 12'($random(seed));
    sb = 8'($random(seed));
    pcx = {a[11:8], sb};
    {tbl_ptr_high, tbl_ptr_low} <= a;
    tbl_dest_sel <= sb;
    wr(12'h000);
    wr(12'h001);
    wr(a);
    wr(pcx);
    q.push_back({9'h000, m[0]});
    cyc(1'b0);
    pc_load <= 1'b1;
    q.push_back({9'h000, m[1]});
    cyc(1'b0);
    pc_load <= 1'b0;
    pc_low_wr <= 1'b1;
    q.push_back({9'h000, m[a]});
    cyc(1'b0);
    pc_low_wr <= 1'b0;
    q.push_back({9'h000, m[pcx]});
    cyc(1'b0);
    pcx = pcx + 12'h001;
    $display("fetch test done");
    for (int i = 0; i < 10; i++)
    begin
      a = (i == 0) ? 12'hFFF : 12'($random(seed));
      e = {i[0] ? 4'hF : a[11:8], a[7:0]};
      wr(e);
      tbl_last_page <= i[0];
      {tbl_ptr_high, tbl_ptr_low} <= a;
      tbl_dest_sel <= 8'($random(seed));
      tbl_high_wr <= 1'b1;
      cyc(1'b1);
      q.push_back({tbl_dest_sel, m[e][7:0], 1'b0, m[e][14:8]});
      cyc(1'b0);
      tbl_high_wr <= 1'b0;
    end
    wr(pcx);
    q.push_back({9'h000, m[pcx]});
    cyc(1'b0);
    $display("table test done");
    dbg_mode <= 1'b1;
    repeat (8) @(posedge ref_clk);
    chk({23'h0, pin_func_en}, 24'h0);
    sb = 8'($random(seed));
    for (int k = 7; k >= 0; k--)
      q.push_back({23'h0, sb[k]});
    #1 pmtr_prog_model_i.send(sb);
    drain;
    repeat (8) @(posedge ref_clk);
    prog_out_en <= 1'b1;
    prog_out_bit <= sb[4];
    q.push_back({23'h0, ~sb[0]});
    q.push_back({23'h0, sb[4]});
    #1 pmtr_prog_model_i.pulse(2);
    drain;
    chk({22'h0, oe, so}, {22'h0, 1'b1, sb[4]});
    $display("serial test done");
    stop_test;
  end
endmodule // program_memory_table_read_bench
`default_nettype wire
